// *** src/dpl_core.sv ***
`timescale 1ns/1ns
module dpl_core
    import dpl_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic                 count_clk,
    input  wire logic                 edit_clk,
    input  wire logic                 cnt_enable,
    input  wire logic                 cnt_down,
    input  wire logic [DPL_SEL_W-1:0] len_sel,
    input  wire logic                 xor_ref_in,
    input  wire logic                 edge_ref_in,
    input  wire logic                 fb_phase_in,
    output logic                      xor_detect_out,
    output logic                      edge_detect_out,
    output logic                      carry_out,
    output logic                      borrow_out,
    output logic                      edit_out
);

    logic [DPL_CNT_W-1:0] cnt_reg;
    logic [DPL_CNT_W-1:0] cnt_next;
    logic [DPL_CNT_W-1:0] len_mask;
    logic [DPL_CNT_W-1:0] cnt_masked;
    logic                 carry_reg;
    logic                 carry_next;
    logic                 borrow_reg;
    logic                 borrow_next;
    logic                 kclk_reg;
    logic                 kclk_rise;
    logic                 cnt_run;
    logic                 xor_reg;
    logic                 xor_next;
    logic                 edge_reg;
    logic                 edge_next;
    logic                 fb_reg;
    logic                 eref_reg;
    logic                 fb_fall;
    logic                 eref_fall;

    // Active stages of the counter number the length code plus two
    generate
        for (genvar i = 0; i < DPL_CNT_W; i++) begin : g_mask
            assign len_mask[i] = (len_sel != DPL_SEL_OFF)
                && (({1'b0, len_sel} + DPL_LEN_BIAS) > 5'(i));
        end
    endgenerate

    // Count clock edge and run qualifier
    assign kclk_rise  = count_clk & ~kclk_reg;
    assign cnt_run    = kclk_rise && cnt_enable && (len_sel != DPL_SEL_OFF);
    assign cnt_masked = cnt_reg & len_mask;

    // Loop filter counter with wrap pulses
    always_comb begin
        cnt_next    = cnt_reg;
        carry_next  = 1'b0;
        borrow_next = 1'b0;
        if (cnt_run) begin
            if (cnt_down) begin
                if (cnt_masked == DPL_CNT_RST) begin
                    cnt_next    = len_mask;
                    borrow_next = 1'b1;
                end else begin
                    cnt_next = cnt_masked - 17'h00001;
                end
            end else begin
                if (cnt_masked == len_mask) begin
                    cnt_next   = DPL_CNT_RST;
                    carry_next = 1'b1;
                end else begin
                    cnt_next = cnt_masked + 17'h00001;
                end
            end
        end
    end

    // Phase detectors
    assign fb_fall   = fb_reg & ~fb_phase_in;
    assign eref_fall = eref_reg & ~edge_ref_in;

    always_comb begin
        xor_next  = xor_ref_in ^ fb_phase_in;
        edge_next = edge_reg;
        if (fb_fall && !eref_fall) begin
            edge_next = 1'b1;
        end else if (eref_fall && !fb_fall) begin
            edge_next = 1'b0;
        end
    end

    // Registers of counter and detectors
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_reg    <= DPL_CNT_RST;
            carry_reg  <= DPL_BIT_RST;
            borrow_reg <= DPL_BIT_RST;
            kclk_reg   <= DPL_BIT_RST;
            xor_reg    <= DPL_BIT_RST;
            edge_reg   <= DPL_BIT_RST;
            fb_reg     <= DPL_BIT_RST;
            eref_reg   <= DPL_BIT_RST;
        end else begin
            cnt_reg    <= cnt_next;
            carry_reg  <= carry_next;
            borrow_reg <= borrow_next;
            kclk_reg   <= count_clk;
            xor_reg    <= xor_next;
            edge_reg   <= edge_next;
            fb_reg     <= fb_phase_in;
            eref_reg   <= edge_ref_in;
        end
    end

    assign xor_detect_out  = xor_reg;
    assign edge_detect_out = edge_reg;
    assign carry_out       = carry_reg;
    assign borrow_out      = borrow_reg;

    // Increment/decrement circuit on the edit clock
    dpl_edit u_edit (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .edit_clk  (edit_clk),
        .carry_in  (carry_reg),
        .borrow_in (borrow_reg),
        .edit_out  (edit_out)
    );

    sequence s_up_top;
        cnt_run && !cnt_down && (cnt_masked == len_mask);
    endsequence

    sequence s_down_zero;
        cnt_run && cnt_down && (cnt_masked == DPL_CNT_RST);
    endsequence

    sequence s_up_step;
        cnt_run && !cnt_down && (cnt_masked != len_mask);
    endsequence

    sequence s_down_step;
        cnt_run && cnt_down && (cnt_masked != DPL_CNT_RST);
    endsequence

    a_inhibit_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        (len_sel == DPL_SEL_OFF) |=> !carry_reg && !borrow_reg && $stable(cnt_reg))
        else $error("inhibited counter moved or pulsed");
    a_carry_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
        s_up_top |=> carry_reg && (cnt_reg == DPL_CNT_RST) ##1 !carry_reg)
        else $error("up wrap did not give a single carry");
    a_borrow_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
        s_down_zero |=> borrow_reg && (cnt_reg == $past(len_mask)))
        else $error("down wrap did not give a borrow");
    a_count_step: assert property (@(posedge mclk) disable iff (sys_rst)
        s_up_step |=> (cnt_reg == $past(cnt_masked) + 17'h00001) && !carry_reg)
        else $error("counter did not step up by one");
    a_pulse_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        carry_reg |-> $past(kclk_rise) && !$past(cnt_down))
        else $error("carry without an up count edge");
    a_len_mod8: assert property (@(posedge mclk) disable iff (sys_rst)
        cnt_run && (len_sel == DPL_SEL_MIN) |=> (cnt_reg <= DPL_MOD8_TOP))
        else $error("shortest length exceeded modulo eight");
    a_count_down: assert property (@(posedge mclk) disable iff (sys_rst)
        s_down_step |=> (cnt_reg == $past(cnt_masked) - 17'h00001) && !borrow_reg)
        else $error("counter did not step down by one");
    a_borrow_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        borrow_reg |-> $past(kclk_rise) && $past(cnt_down))
        else $error("borrow without a down count edge");
    a_borrow_single: assert property (@(posedge mclk) disable iff (sys_rst)
        borrow_reg |=> !borrow_reg)
        else $error("borrow pulse longer than one cycle");
    a_idle_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !cnt_run |=> $stable(cnt_reg) && !carry_reg && !borrow_reg)
        else $error("counter moved without a count edge");
    a_len_top: assert property (@(posedge mclk) disable iff (sys_rst)
        cnt_run |=> ((cnt_reg & ~$past(len_mask)) == DPL_CNT_RST))
        else $error("count reached stages beyond the length code");
    a_reset_clear: assert property (@(posedge mclk)
        sys_rst |=> (cnt_reg == DPL_CNT_RST) && !carry_reg && !borrow_reg
            && !xor_detect_out && !edge_detect_out)
        else $error("counter or detectors not clear after reset");

    // Detector checks
    a_xor_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (xor_ref_in == fb_phase_in) ##1 (xor_ref_in == fb_phase_in) |-> !xor_detect_out)
        else $error("xor detector high while inputs agree");
    a_xor_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        (xor_ref_in != fb_phase_in) ##1 (xor_ref_in != fb_phase_in) |-> xor_detect_out)
        else $error("xor detector low while inputs differ");
    a_edge_set: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(fb_phase_in) && !$fell(edge_ref_in) |=> edge_detect_out)
        else $error("edge detector missed feedback fall");
    a_edge_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(edge_ref_in) && !$fell(fb_phase_in) |=> !edge_detect_out)
        else $error("edge detector missed reference fall");
    a_edge_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !$fell(edge_ref_in) && !$fell(fb_phase_in) |=> $stable(edge_detect_out))
        else $error("edge detector moved without a falling edge");
    a_edge_both: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(fb_phase_in) && $fell(edge_ref_in) |=> $stable(edge_detect_out))
        else $error("edge detector moved on simultaneous falls");

endmodule

// *** src/dpl_pkg.sv ***
package dpl_pkg;

    // Loop filter counter geometry
    localparam int              DPL_CNT_W    = 17;
    localparam int              DPL_SEL_W    = 4;
    localparam logic [4:0]      DPL_LEN_BIAS = 5'h02;  // Stages = select code + 2
    localparam logic [3:0]      DPL_SEL_OFF  = 4'h0;   // Code that inhibits the counter
    localparam logic [3:0]      DPL_SEL_MIN  = 4'h1;   // Shortest length, three stages
    localparam logic [16:0]     DPL_MOD8_TOP = 17'h00007;

    // Values after reset
    localparam logic [16:0]     DPL_CNT_RST  = 17'h00000;
    localparam logic            DPL_BIT_RST  = 1'b0;

    // Increment/decrement circuit states
    typedef enum logic [3:0] {
        DPL_ID_IDLE = 4'h1,
        DPL_ID_ADD1 = 4'h2,
        DPL_ID_ADD2 = 4'h4,
        DPL_ID_DEL  = 4'h8
    } dpl_id_state_t;

endpackage

// *** src/dpl_edit.sv ***
`timescale 1ns/1ns
module dpl_edit
    import dpl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic edit_clk,
    input  wire logic carry_in,
    input  wire logic borrow_in,
    output logic      edit_out
);

    logic          eclk_reg;
    logic          pend_carry_reg;
    logic          pend_carry_next;
    logic          pend_borrow_reg;
    logic          pend_borrow_next;
    logic          out_reg;
    logic          out_next;
    dpl_id_state_t state_reg;
    dpl_id_state_t state_next;
    logic          erise;
    logic          efall;
    logic          take_carry;
    logic          take_borrow;

    assign erise    = edit_clk & ~eclk_reg;
    assign efall    = ~edit_clk & eclk_reg;
    assign edit_out = out_reg;

    // Halve the edit clock, adding or deleting two toggles on request
    always_comb begin
        state_next  = state_reg;
        out_next    = out_reg;
        take_carry  = 1'b0;
        take_borrow = 1'b0;
        case (state_reg)
            DPL_ID_IDLE: begin
                if (erise) begin
                    if (pend_carry_reg && pend_borrow_reg) begin
                        out_next    = ~out_reg;  // Carry and borrow cancel
                        take_carry  = 1'b1;
                        take_borrow = 1'b1;
                    end else if (pend_carry_reg) begin
                        out_next   = ~out_reg;
                        take_carry = 1'b1;
                        state_next = DPL_ID_ADD1;
                    end else if (pend_borrow_reg) begin
                        take_borrow = 1'b1;
                        state_next  = DPL_ID_DEL;
                    end else begin
                        out_next = ~out_reg;
                    end
                end
            end
            DPL_ID_ADD1: begin
                if (efall) begin
                    out_next   = ~out_reg;
                    state_next = DPL_ID_ADD2;
                end
            end
            DPL_ID_ADD2: begin
                if (erise) begin
                    out_next = ~out_reg;
                end else if (efall) begin
                    out_next   = ~out_reg;
                    state_next = DPL_ID_IDLE;
                end
            end
            DPL_ID_DEL: begin
                if (erise) begin
                    state_next = DPL_ID_IDLE;
                end
            end
            default: begin
                state_next = DPL_ID_IDLE;
            end
        endcase
    end

    // Pending requests; a new pulse wins over the clear
    always_comb begin
        pend_carry_next  = (pend_carry_reg & ~take_carry) | carry_in;
        pend_borrow_next = (pend_borrow_reg & ~take_borrow) | borrow_in;
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg       <= DPL_ID_IDLE;
            out_reg         <= DPL_BIT_RST;
            eclk_reg        <= DPL_BIT_RST;
            pend_carry_reg  <= DPL_BIT_RST;
            pend_borrow_reg <= DPL_BIT_RST;
        end else begin
            state_reg       <= state_next;
            out_reg         <= out_next;
            eclk_reg        <= edit_clk;
            pend_carry_reg  <= pend_carry_next;
            pend_borrow_reg <= pend_borrow_next;
        end
    end

    sequence s_quiet_rise;
        (state_reg == DPL_ID_IDLE) && !pend_carry_reg && !pend_borrow_reg && erise;
    endsequence

    sequence s_carry_rise;
        (state_reg == DPL_ID_IDLE) && pend_carry_reg && !pend_borrow_reg && erise;
    endsequence

    sequence s_borrow_rise;
        (state_reg == DPL_ID_IDLE) && !pend_carry_reg && pend_borrow_reg && erise;
    endsequence

    a_half_rate: assert property (@(posedge mclk) disable iff (sys_rst)
        s_quiet_rise |=> (out_reg != $past(out_reg)))
        else $error("edit output did not toggle on edit clock");
    a_add_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        s_carry_rise |=> (state_reg == DPL_ID_ADD1) && (pend_carry_reg == $past(carry_in)))
        else $error("carry did not start an insertion");
    a_del_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == DPL_ID_DEL) && erise |=> $stable(out_reg) && (state_reg == DPL_ID_IDLE))
        else $error("deletion did not swallow a toggle");
    a_del_first: assert property (@(posedge mclk) disable iff (sys_rst)
        s_borrow_rise |=> $stable(out_reg) && (state_reg == DPL_ID_DEL))
        else $error("borrow did not start a deletion");
    a_pend_cancel: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == DPL_ID_IDLE) && pend_carry_reg && pend_borrow_reg && erise
        |=> (out_reg != $past(out_reg)) && (state_reg == DPL_ID_IDLE))
        else $error("carry and borrow together did not cancel");
    a_pend_catch: assert property (@(posedge mclk) disable iff (sys_rst)
        carry_in |=> pend_carry_reg)
        else $error("carry pulse was lost");
    a_reset_idle: assert property (@(posedge mclk)
        sys_rst |=> (state_reg == DPL_ID_IDLE) && !pend_carry_reg && !pend_borrow_reg)
        else $error("edit circuit not idle after reset");

endmodule

// *** bench/dpl_fb_model.sv ***
`timescale 1ns/1ns
// Outside divide-by-N counter that closes the loop from the edit output
module dpl_fb_model #(
    parameter int DIV_N = 4
) (
    mclk,
    sys_rst,
    edit_out,
    fb_phase_out
);
    input  wire logic mclk;
    input  wire logic sys_rst;
    input  wire logic edit_out;
    output logic      fb_phase_out;

    int   cnt_reg;
    logic prev_reg;

    // Count edit output rises modulo N
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_reg  <= 0;
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= edit_out;
            if (edit_out && !prev_reg) begin
                cnt_reg <= (cnt_reg == DIV_N - 1) ? 0 : cnt_reg + 1;
            end
        end
    end

    // High for the second half of each division
    assign fb_phase_out = (cnt_reg >= DIV_N / 2);
endmodule

// *** bench/dpl_core_tb_top.sv ***
`timescale 1ns/1ns
module dpl_core_tb_top;
    import dpl_pkg::*;
    logic                 mclk, sys_rst, count_clk, edit_clk, cnt_enable, tb_down;
    logic [DPL_SEL_W-1:0] len_sel;
    logic                 xor_ref_in, edge_ref_in, tb_fb, use_loop, edit_prev, fb_prev;
    wire logic            cnt_down, fb_phase_in, model_fb;
    logic                 xor_detect_out, edge_detect_out, carry_out, borrow_out, edit_out;
    int                   failures, tests_run, carry_cnt, borrow_cnt, tog_cnt, fb_rise;

    // Closed loop wiring: detector steers direction, divider feeds back
    assign cnt_down    = use_loop ? xor_detect_out : tb_down;
    assign fb_phase_in = use_loop ? model_fb : tb_fb;

    dpl_core dpl_core_inst (.mclk(mclk), .sys_rst(sys_rst), .count_clk(count_clk),
        .edit_clk(edit_clk), .cnt_enable(cnt_enable), .cnt_down(cnt_down),
        .len_sel(len_sel), .xor_ref_in(xor_ref_in), .edge_ref_in(edge_ref_in),
        .fb_phase_in(fb_phase_in), .xor_detect_out(xor_detect_out),
        .edge_detect_out(edge_detect_out), .carry_out(carry_out),
        .borrow_out(borrow_out), .edit_out(edit_out));
    dpl_fb_model #(.DIV_N(4)) dpl_fb_model_inst (.mclk(mclk), .sys_rst(sys_rst),
        .edit_out(edit_out), .fb_phase_out(model_fb));

    // Clock
    always #5 mclk = ~mclk;

    // Pulse and toggle counters
    always @(posedge mclk) begin
        if (!sys_rst) begin
            if (carry_out === 1'b1) carry_cnt++;
            if (borrow_out === 1'b1) borrow_cnt++;
            if (edit_out !== edit_prev) tog_cnt++;
            if (fb_phase_in === 1'b1 && fb_prev === 1'b0) fb_rise++;
        end
        edit_prev = edit_out;
        fb_prev   = fb_phase_in;
    end

    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task kstep(input int n);
        repeat (n) begin
            count_clk = 1'b1;
            tick(2);
            count_clk = 1'b0;
            tick(2);
        end
    endtask
    task estep(input int n);
        repeat (n) begin
            edit_clk = 1'b1;
            tick(3);
            edit_clk = 1'b0;
            tick(3);
        end
    endtask
    task do_reset;
        sys_rst = 1'b1;
        tick(20);
        sys_rst = 1'b0;
        tick(1);
    endtask
    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Lengths 1 to 4 from a cleared count each wrap after exactly 2^(n+2) steps
    task t_modulo;
        cnt_enable = 1'b1;
        tb_down    = 1'b0;
        for (int n = 1; n <= 4; n++) begin
            len_sel   = n[3:0];
            carry_cnt = 0;
            kstep((1 << (n + 2)) - 1);
            check("carry before wrap", 0, carry_cnt);
            kstep(1);
            check("carry at wrap", 1, carry_cnt);
        end
        $display("done modulo");
    endtask
    // Down from zero borrows, then up from the top carries
    task t_borrow;
        tb_down    = 1'b1;
        borrow_cnt = 0;
        kstep(1);
        check("borrow at zero", 1, borrow_cnt);
        tb_down   = 1'b0;
        carry_cnt = 0;
        kstep(1);
        check("carry from top", 1, carry_cnt);
        $display("done borrow");
    endtask
    // Length zero or enable low gives no pulses
    task t_inhibit;
        len_sel    = 4'h0;
        carry_cnt  = 0;
        borrow_cnt = 0;
        kstep(20);
        check("pulses with length zero", 0, carry_cnt + borrow_cnt);
        len_sel    = 4'h1;
        cnt_enable = 1'b0;
        kstep(20);
        check("pulses while disabled", 0, carry_cnt + borrow_cnt);
        cnt_enable = 1'b1;
        $display("done inhibit");
    endtask
    // Edit output toggle count: plain, one insert, one delete, both cancel
    task t_edit(input logic dn, input int steps, input int back, input int exp_tog);
        do_reset();
        check("outputs after reset", 0, {xor_detect_out, edge_detect_out, carry_out,
            borrow_out, edit_out});
        len_sel = 4'h1;
        tb_down = dn;
        kstep(steps);
        tb_down = ~dn;
        kstep(back);
        tog_cnt = 0;
        estep(10);
        check("edit toggles", exp_tog, tog_cnt);
        $display("done edit");
    endtask
    // Exclusive-OR truth table
    task t_xor_table;
        logic [1:0] v;
        for (int i = 0; i < 4; i++) begin
            v          = i[1:0];
            xor_ref_in = v[1];
            tb_fb      = v[0];
            tick(2);
            check("xor output", v[1] ^ v[0], xor_detect_out);
        end
        $display("done xor table");
    endtask
    // Edge detector: single falls act, rises and simultaneous falls hold
    task t_edge;
        tb_fb       = 1'b1;
        edge_ref_in = 1'b1;
        tick(2);
        edge_ref_in = 1'b0;
        tick(2);
        check("edge after ref fall", 0, edge_detect_out);
        edge_ref_in = 1'b1;
        tick(2);
        check("edge after ref rise", 0, edge_detect_out);
        tb_fb = 1'b0;
        tick(2);
        check("edge after fb fall", 1, edge_detect_out);
        tb_fb = 1'b1;
        tick(2);
        check("edge after fb rise", 1, edge_detect_out);
        {tb_fb, edge_ref_in} = 2'b00;
        tick(2);
        check("edge after both fall", 1, edge_detect_out);
        $display("done edge");
    endtask
    // Offset square waves of period 8; count detector highs over 32 cycles
    task t_phase(input int off, input logic edg, input int exp_hi);
        int         hi;
        logic [5:0] u;
        hi = 0;
        for (int k = 0; k < 40; k++) begin
            u     = 6'(k - off);
            tb_fb = k[2];
            if (edg) edge_ref_in = u[2];
            else xor_ref_in = u[2];
            tick(1);
            if (k >= 8) hi += ((edg ? edge_detect_out : xor_detect_out) === 1'b1);
        end
        check("detector high count", exp_hi, hi);
        $display("done phase");
    endtask
    // Closed loop through the divider: 8 edit pulses give 2 feedback rises
    task t_loop;
        do_reset();
        use_loop = 1'b1;
        len_sel  = 4'h0;
        fb_rise  = 0;
        estep(16);
        check("feedback rises", 2, fb_rise);
        use_loop = 1'b0;
        $display("done loop");
    endtask

    // Watchdog
    initial begin
        #300000;
        failures++;
        summarize();
    end

    // Main sequence
    initial begin
        {mclk, count_clk, edit_clk, tb_down, xor_ref_in, edge_ref_in, tb_fb} = '0;
        {use_loop, edit_prev, fb_prev, cnt_enable} = '0;
        len_sel   = 4'h0;
        failures  = 0;
        tests_run = 0;
        {carry_cnt, borrow_cnt, tog_cnt, fb_rise} = '0;
        do_reset();
        t_modulo();
        t_borrow();
        t_inhibit();
        t_edit(1'b0, 0, 0, 10);
        t_edit(1'b0, 8, 0, 12);
        t_edit(1'b1, 1, 0, 8);
        t_edit(1'b0, 8, 1, 10);
        t_xor_table();
        t_edge();
        t_phase(2, 1'b0, 16);
        t_phase(4, 1'b0, 32);
        t_phase(4, 1'b1, 16);
        t_loop();
        summarize();
    end
endmodule
